// ==== core/fscc_pkg.sv ====
// Package of constants and types for the full-scan chain control block.
// Functional notes
// - Every chain storage flop is a multiplexed scan flop taking either functional or serial scan data; the output registers are plain flops.
// - Shift mode is chosen by the scan shift select input, driven by the tester; capture mode also needs the test-fixing input high.
// - In shift mode the scan flops form a serial shift register moving one place per clock edge.
// - In capture mode the loaded state drives the functional logic and the next edge captures the response.
// - Scan shift select comes from its own dedicated input pin shared with nothing else.
// - While shifting, the asynchronous set and reset of the scan flops are held inactive.
// - While shifting, the bidirectional pin direction controls are forced to a fixed known direction.
// - Every scan flop clock comes straight from the external clock pin with no divider in between.
// - Each chain takes its serial input from a scan data input pin, a dedicated input that needs no direction control.
// - Each chain drives its last stage onto a scan data output pin, held as output during test.
// - The test-fixing input holds asynchronous logic at fixed values and fixes the scan output and bidirectional pin directions.
package fscc_pkg;
	localparam int          CHAIN_COUNT  = 2;
	localparam int          CHAIN_LENGTH = 8;
	localparam int          DATA_WIDTH   = CHAIN_COUNT * CHAIN_LENGTH;
	localparam int          BIDIR_WIDTH  = 4;
	localparam logic [15:0] STATE_RESET  = 16'h0000;
	localparam logic        SHIFT_ACTIVE = 1'b1;
	localparam logic        PIN_IN_DIR   = 1'b0;
	localparam logic        PIN_OUT_DIR  = 1'b1;
	typedef enum logic [1:0] {
		FSCC_FUNCTIONAL,
		FSCC_SHIFT,
		FSCC_CAPTURE
	} fscc_mode_type;
endpackage

// ==== core/fscc_flop_if.sv ====
// Interface carrying the control lines shared by all scan flops.
`timescale 1ns/1ps
interface fscc_flop_if;
	logic shift_sel;
	logic async_clear;
	modport ctrl (output shift_sel, output async_clear);
	modport flop (input shift_sel, input async_clear);
endinterface

// ==== core/fscc_muxed_scan_flop.sv ====
// One multiplexed scan flop whose asynchronous-clear request overrides both data inputs.
`timescale 1ns/1ps
module fscc_muxed_scan_flop (
	input  wire logic  mclk,
	input  wire logic  sys_rst,
	fscc_flop_if.flop  ctl,
	input  wire logic  func_d,
	input  wire logic  scan_d,
	output logic       q
);
	import fscc_pkg::*;
	logic next_q;
	always_comb begin
		if (ctl.async_clear)
			next_q = 1'b0;
		else if (ctl.shift_sel == SHIFT_ACTIVE)
			next_q = scan_d;
		else
			next_q = func_d;
	end
	// Clock is the raw pin clock; no divider may sit in front of it.
	always_ff @(posedge mclk) begin
		if (sys_rst)
			q <= 1'b0;
		else
			q <= next_q;
	end
endmodule

// ==== core/fscc_top.sv ====
// Scan-wrapped example core with chain control and pin direction fixing.
`timescale 1ns/1ps
module fscc_top #(
	parameter int CHAINS = fscc_pkg::CHAIN_COUNT,
	parameter int LENGTH = fscc_pkg::CHAIN_LENGTH,
	parameter int BIDIRS = fscc_pkg::BIDIR_WIDTH
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic              scan_shift_select,
	input  wire logic              test_fixing_input,
	input  wire logic [CHAINS-1:0] scan_in,
	output logic      [CHAINS-1:0] scan_out,
	output logic      [CHAINS-1:0] scan_out_oe,
	input  wire logic              func_clear,
	input  wire logic [BIDIRS-1:0] bidir_i,
	output logic      [BIDIRS-1:0] bidir_o,
	output logic      [BIDIRS-1:0] bidir_oe,
	output logic      [1:0]        mode
);
	import fscc_pkg::*;

	// A chain needs a head stage and a body stage to shift at all.
	if (CHAINS < 1 || LENGTH < 2 || BIDIRS < 1) begin : g_bad_size
		$error("fscc_top: unsupported chain or pin sizing.");
	end

	localparam int NFLOP = CHAINS * LENGTH;

	////////////////////////////////////////////////////////////////////////
	fscc_flop_if ctl ();
	logic [NFLOP-1:0] q;
	logic [NFLOP-1:0] func_d;
	logic [NFLOP-1:0] scan_d;

	// Dedicated pin: the select reaches the flops with no other source.
	assign ctl.shift_sel = scan_shift_select;
	// Functional clear is suppressed while shifting, and pinned off by the
	// test-fixing input so a capture cannot be spoiled by an async path.
	assign ctl.async_clear = func_clear && !scan_shift_select
		&& !test_fixing_input;

	////////////////////////////////////////////////////////////////////////
	// Example functional logic: each chain word rotates and mixes in the
	// pin inputs, so capture mode observes a real combinational response.
	genvar c, s;
	generate
		for (c = 0; c < CHAINS; c++) begin : g_chain
			for (s = 0; s < LENGTH; s++) begin : g_stage
				localparam int I = c * LENGTH + s;
				localparam int P = c * LENGTH + ((s + LENGTH - 1) % LENGTH);
				assign func_d[I] = q[P] ^ bidir_i[I % BIDIRS];
				if (s == 0) begin : g_head
					assign scan_d[I] = scan_in[c];
				end else begin : g_body
					assign scan_d[I] = q[I-1];
				end
				fscc_muxed_scan_flop u_flop (
					.mclk    (mclk),
					.sys_rst (sys_rst),
					.ctl     (ctl),
					.func_d  (func_d[I]),
					.scan_d  (scan_d[I]),
					.q       (q[I])
				);
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Output registers: every top output comes from a flop. The pin
	// outputs are themselves muxed scan flops in spirit, but are kept off
	// the chains so the tester sees a stable chain length.
	logic [CHAINS-1:0] next_scan_out;
	logic [CHAINS-1:0] next_scan_out_oe;
	logic [BIDIRS-1:0] next_bidir_o;
	logic [BIDIRS-1:0] next_bidir_oe;
	fscc_mode_type     next_mode;

	always_comb begin
		next_scan_out    = '0;
		next_scan_out_oe = '0;
		for (int k = 0; k < CHAINS; k++) begin
			next_scan_out[k] = q[k*LENGTH + LENGTH - 1];
			if (scan_shift_select || test_fixing_input)
				next_scan_out_oe[k] = PIN_OUT_DIR;
			else
				next_scan_out_oe[k] = PIN_IN_DIR;
		end
		for (int k = 0; k < BIDIRS; k++) begin
			next_bidir_o[k] = q[k % NFLOP];
			if (scan_shift_select)
				next_bidir_oe[k] = PIN_IN_DIR;
			else if (test_fixing_input)
				next_bidir_oe[k] = PIN_IN_DIR;
			else
				next_bidir_oe[k] = q[NFLOP - 1 - (k % NFLOP)];
		end
		if (scan_shift_select == SHIFT_ACTIVE)
			next_mode = FSCC_SHIFT;
		else if (test_fixing_input)
			next_mode = FSCC_CAPTURE;
		else
			next_mode = FSCC_FUNCTIONAL;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			scan_out    <= '0;
			scan_out_oe <= '0;
			bidir_o     <= '0;
			bidir_oe    <= '0;
			mode        <= FSCC_FUNCTIONAL;
		end else begin
			scan_out    <= next_scan_out;
			scan_out_oe <= next_scan_out_oe;
			bidir_o     <= next_bidir_o;
			bidir_oe    <= next_bidir_oe;
			mode        <= next_mode;
		end
	end
endmodule

// ==== verif/fscc_props.sv ====
// Concurrent checks on the scan pins of the top module.
`timescale 1ns/1ps
module fscc_props #(
	parameter int CHAINS = 2,
	parameter int LENGTH = 8,
	parameter int BIDIRS = 4
) (
	input wire logic              mclk,
	input wire logic              sys_rst,
	input wire logic              scan_shift_select,
	input wire logic              test_fixing_input,
	input wire logic [CHAINS-1:0] scan_in,
	input wire logic [CHAINS-1:0] scan_out,
	input wire logic [CHAINS-1:0] scan_out_oe,
	input wire logic              func_clear,
	input wire logic [BIDIRS-1:0] bidir_i,
	input wire logic [BIDIRS-1:0] bidir_o,
	input wire logic [BIDIRS-1:0] bidir_oe,
	input wire logic [1:0]        mode
);
	int   run;
	logic arm1;
	logic arm2;
	wire  pin = bidir_i[(LENGTH-1)%BIDIRS];
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Run counts unbroken shift edges so chain contents are known.
	always_ff @(posedge mclk) begin
		run  <= sys_rst ? 0 : (scan_shift_select ? run + 1 : 0);
		arm1 <= !sys_rst && run >= LENGTH - 1 && !scan_shift_select
			&& (test_fixing_input || !func_clear);
		arm2 <= arm1 && !sys_rst;
	end
	sequence s_clear;
		!scan_shift_select && !test_fixing_input && func_clear;
	endsequence
	chk_shift_path: assert property (run >= LENGTH + 1 |->
		scan_out == $past(scan_in, LENGTH + 1)) else $error("shift path");
	chk_capture_path: assert property (arm2 |-> scan_out ==
		($past(scan_in, LENGTH + 1) ^ {CHAINS{$past(pin, 2)}}))
		else $error("capture path");
	chk_clear_func: assert property (s_clear |-> ##2 scan_out == '0)
		else $error("clear ignored");
	chk_mode_shift: assert property (scan_shift_select |=> mode == 2'h1)
		else $error("mode shift");
	chk_mode_fix: assert property (!scan_shift_select &&
		test_fixing_input |=> mode == 2'h2) else $error("mode fix");
	chk_mode_func: assert property (!scan_shift_select &&
		!test_fixing_input |=> mode == 2'h0) else $error("mode func");
	chk_pin_dir: assert property (scan_shift_select || test_fixing_input
		|=> bidir_oe == '0 && scan_out_oe == '1) else $error("pin dir");
	chk_oe_func: assert property (!scan_shift_select && !test_fixing_input
		|=> scan_out_oe == '0) else $error("oe func");
endmodule
bind fscc_top fscc_props #(.CHAINS(CHAINS), .LENGTH(LENGTH), .BIDIRS(BIDIRS))
	u_props (.*);

// ==== verif/fscc_ate.sv ====
// Tester model that drives the scan select and serial data pins.
`timescale 1ns/1ps
module fscc_ate (
	input  wire logic       mclk,
	input  wire logic       shift_req,
	output logic            scan_shift_select,
	output logic      [1:0] scan_in
);
	int seed = 32'h4ABF;
	initial begin
		scan_shift_select = 1'b0;
		scan_in = 2'h0;
	end
	always @(posedge mclk) begin
		scan_shift_select <= shift_req;
		scan_in <= $random(seed);
	end
endmodule

// ==== verif/full_scan_chain_control_tb.sv ====
// Testbench comparing the scan block with a reference chain model.
`timescale 1ns/1ps
module full_scan_chain_control_tb;
	logic        mclk = 0, sys_rst = 1, shift_req = 0, tfi = 0, clr = 0, sel, f;
	logic [1:0]  scan_in, scan_out, scan_out_oe, mode;
	logic [3:0]  bidir_i = 0, bidir_o, bidir_oe;
	logic [15:0] q, nq;
	logic [13:0] e = 0;
	int          seed = 32'h4ABF, n_fail = 0, total_checks = 0, cyc = 0, t = 0;
	initial forever #20 mclk = ~mclk;
	fscc_ate u_ate (.mclk(mclk), .shift_req(shift_req),
		.scan_shift_select(sel), .scan_in(scan_in));
	fscc_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .scan_shift_select(sel),
		.test_fixing_input(tfi), .scan_in(scan_in), .scan_out(scan_out),
		.scan_out_oe(scan_out_oe), .func_clear(clr), .bidir_i(bidir_i),
		.bidir_o(bidir_o), .bidir_oe(bidir_oe), .mode(mode));
	task give_verdict;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge mclk) begin
		f = sel | tfi;
		e <= sys_rst ? 14'h0 : {q[15], q[7], {2{f}}, q[3:0], f ? 4'h0 :
			{q[12], q[13], q[14], q[15]}, sel ? 2'h1 : {tfi, 1'b0}};
		for (int i = 0; i < 16; i++)
			nq[i] = sel ? (i % 8 ? q[i-1] : scan_in[i/8]) : !tfi && clr ?
				1'b0 : q[i/8*8+(i+7)%8] ^ bidir_i[i%4];
		q <= sys_rst ? 16'h0 : nq;
		t++;
		if (t == 3000) begin
			n_fail++;
			give_verdict;
		end
	end
	always @(negedge mclk) begin
		total_checks++;
		if ({scan_out, scan_out_oe, bidir_o, bidir_oe, mode} !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time,
				{scan_out, scan_out_oe, bidir_o, bidir_oe, mode}, e);
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		sys_rst <= 0;
		repeat (1500) begin
			@(posedge mclk);
			cyc++;
			shift_req <= cyc < 700 ? cyc % 13 != 0 : $random(seed);
			tfi <= $random(seed);
			clr <= $random(seed);
			bidir_i <= $random(seed);
			sys_rst <= cyc == 900;
		end
		give_verdict;
	end
endmodule
